// *** common/ntbc_pkg.sv ***
// Purpose: shared constants and carriers of the bridge endpoint config header
// Assumes: dword-addressed configuration requests with byte enables
// Notes:   byte offsets are kept whole; decode uses their dword part
package ntbc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // address map, byte offsets within configuration space
    localparam logic [11:0] OFS_SUBSYS_VENDOR = 12'h02c;
    localparam logic [11:0] OFS_SUBSYS        = 12'h02e;
    localparam logic [11:0] OFS_CAP_HEAD      = 12'h034;
    localparam logic [11:0] OFS_INTR_LINE     = 12'h03c;
    localparam logic [11:0] OFS_INTR_PIN      = 12'h03d;
    localparam logic [11:0] OFS_MIN_GRANT     = 12'h03e;
    localparam logic [11:0] OFS_MAX_LATENCY   = 12'h03f;
    localparam logic [11:0] OFS_CAP_HEADER    = 12'h040;
    localparam logic [11:0] OFS_DEV_CAPS      = 12'h044;

    // dword indices of the decoded words
    localparam logic [9:0] DW_SUBSYS  = OFS_SUBSYS_VENDOR[11:2];
    localparam logic [9:0] DW_CAPHEAD = OFS_CAP_HEAD[11:2];
    localparam logic [9:0] DW_INTR    = OFS_INTR_LINE[11:2];
    localparam logic [9:0] DW_CAPHDR  = OFS_CAP_HEADER[11:2];
    localparam logic [9:0] DW_DEVCAP  = OFS_DEV_CAPS[11:2];

    ////////////////////////////////////////////////////////////////////////
    // constant field values and reset values
    localparam logic [7:0]  CAP_HEAD_VAL       = 8'h40;
    localparam logic [7:0]  MIN_GRANT_VAL      = 8'h00;
    localparam logic [7:0]  MAX_LATENCY_VAL    = 8'h00;
    localparam logic [7:0]  CAP_ID_VAL         = 8'h10;
    localparam logic [7:0]  NEXT_CAP_PTR_VAL   = 8'h64;
    localparam logic [3:0]  STRUCT_VERSION_VAL = 4'h1;
    localparam logic [4:0]  INTR_MSG_NUM_VAL   = 5'h00;
    localparam logic [1:0]  PHANTOM_FUNC_VAL   = 2'h0;
    localparam logic        EXT_TAG_VAL        = 1'b1;
    localparam logic [2:0]  L0S_LATENCY_VAL    = 3'h7;
    localparam logic [2:0]  L1_LATENCY_VAL     = 3'h7;

    localparam logic [15:0] SUBSYS_VENDOR_RST  = 16'h0000;
    localparam logic [15:0] SUBSYS_RST         = 16'h0000;
    localparam logic [7:0]  INTR_LINE_RST      = 8'h00;
    localparam logic [7:0]  INTR_PIN_RST       = 8'h00;
    localparam logic [3:0]  PORT_TYPE_RST      = 4'h0;
    localparam logic        SLOT_IMPL_RST      = 1'b0;
    localparam logic [2:0]  MAX_PAYLOAD_RST    = 3'h4;
    localparam logic [2:0]  INDICATORS_RST     = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned POS_SUBSYS_VENDOR = 0;
    localparam int unsigned POS_SUBSYS        = 16;
    localparam int unsigned POS_INTR_LINE     = 0;
    localparam int unsigned POS_INTR_PIN      = 8;
    localparam int unsigned POS_PORT_TYPE     = 20;
    localparam int unsigned POS_SLOT_IMPL     = 24;
    localparam int unsigned POS_MAX_PAYLOAD   = 0;
    localparam int unsigned POS_INDICATORS    = 12;
    localparam int unsigned NUM_INDICATORS    = 3;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [9:0]  dw_addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } ntbc_cfg_req_s;

    typedef struct packed {
        logic        valid;
        logic [9:0]  dw_addr;
        logic [3:0]  be;
        logic [31:0] data;
    } ntbc_load_s;

    // decoded register word
    typedef enum logic [2:0] {
        SEL_NONE    = 3'b000,
        SEL_SUBSYS  = 3'b001,
        SEL_CAPHEAD = 3'b010,
        SEL_INTR    = 3'b011,
        SEL_CAPHDR  = 3'b100,
        SEL_DEVCAP  = 3'b101
    } ntbc_sel_e;

endpackage : ntbc_pkg

// *** rtl/ntbc_cfg_header.sv ***
// Purpose: config header tail and express capability registers
// Assumes: one request per cycle at most; answer one cycle later
// Notes:   unmapped dwords read zero and ignore writes
//
// Contract
// RQ1: 16-bit lockable subsystem vendor code, reset zero.
// RQ2: 16-bit lockable subsystem code, reset zero.
// RQ3: capability list head reads constant 0x40.
// RQ4: interrupt routing line byte is plain read/write, reset zero, unused.
// RQ5: interrupt pin byte lockable, reset zero.
// RQ6: min grant and max latency bytes read zero, writes ignored.
// RQ7: capability identifier reads 0x10.
// RQ8: next capability pointer reads constant 0x64.
// RQ9: structure version reads constant one.
// RQ10: port type lockable, reset zero, loadable from config memory.
// RQ11: slot implemented bit lockable, reset zero.
// RQ12: interrupt message number reads zero.
// RQ13: max payload supported lockable, reset 0x4 (2048 bytes).
// RQ14: phantom functions supported reads zero.
// RQ15: extended tag support reads one.
// RQ16: l0s acceptable latency read-only, 0x7.
// RQ17: l1 acceptable latency read-only, 0x7.
// RQ18: three indicator-present bits reset zero, loadable only.
// RQ19: lockable fields take host writes only while unlocked; loads always.
`timescale 1ns/1ps
module ntbc_cfg_header
    import ntbc_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          srst_i,
    input  wire ntbc_cfg_req_s cfg_req_i,
    input  wire ntbc_load_s    load_i,
    input  wire logic          wr_lock_i,
    output logic               cfg_ack_o,
    output logic               cfg_hit_o,
    output logic        [31:0] cfg_rdata_o,
    output logic        [3:0]  port_type_o,
    output logic               slot_impl_o,
    output logic        [2:0]  max_payload_o
);

    ////////////////////////////////////////////////////////////////////////
    // byte-enable merge of a new dword over the current one
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                r[8*b +: 8] = new_v[8*b +: 8];
        end
        return r;
    endfunction : be_merge

    ////////////////////////////////////////////////////////////////////////
    // address decode, shared by host and loader
    function automatic ntbc_sel_e decode(input logic [9:0] dw);
        ntbc_sel_e s;
        case (dw)
            DW_SUBSYS:  s = SEL_SUBSYS;
            DW_CAPHEAD: s = SEL_CAPHEAD;
            DW_INTR:    s = SEL_INTR;
            DW_CAPHDR:  s = SEL_CAPHDR;
            DW_DEVCAP:  s = SEL_DEVCAP;
            default:    s = SEL_NONE;
        endcase
        return s;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////
    // field storage outputs
    logic [15:0] subsys_vendor;
    logic [15:0] subsys_code;
    logic [7:0]  intr_line_q;
    logic [7:0]  intr_pin;
    logic [3:0]  port_type;
    logic        slot_impl;
    logic [2:0]  max_payload;
    logic [NUM_INDICATORS-1:0] indicators;

    ////////////////////////////////////////////////////////////////////////
    // dword images as the host sees them
    logic [31:0] subsys_dw;
    logic [31:0] caphead_dw;
    logic [31:0] intr_dw;
    logic [31:0] caphdr_dw;
    logic [31:0] devcap_dw;

    assign subsys_dw  = {subsys_code, subsys_vendor};               // RQ1
    assign caphead_dw = {24'h00_0000, CAP_HEAD_VAL};                // RQ3
    assign intr_dw    = {MAX_LATENCY_VAL, MIN_GRANT_VAL,            // RQ6
                         intr_pin, intr_line_q};
    assign caphdr_dw  = {2'b00, INTR_MSG_NUM_VAL, slot_impl,        // RQ12
                         port_type, STRUCT_VERSION_VAL,             // RQ9
                         NEXT_CAP_PTR_VAL, CAP_ID_VAL};             // RQ8
    assign devcap_dw  = {17'h0_0000, indicators,                    // RQ18
                         L1_LATENCY_VAL, L0S_LATENCY_VAL,           // RQ17
                         EXT_TAG_VAL, PHANTOM_FUNC_VAL,             // RQ15
                         max_payload};                              // RQ13

    ////////////////////////////////////////////////////////////////////////
    // decode and write strobes
    ntbc_sel_e   host_sel;
    ntbc_sel_e   load_sel;
    logic        host_wr;
    logic        load_wr;

    assign host_sel = decode(cfg_req_i.dw_addr);
    assign load_sel = decode(load_i.dw_addr);
    assign host_wr  = cfg_req_i.valid && cfg_req_i.write;
    assign load_wr  = load_i.valid;

    // merged write data per word, untouched bytes keep their value
    logic [31:0] h_subsys;
    logic [31:0] h_intr;
    logic [31:0] h_caphdr;
    logic [31:0] h_devcap;
    logic [31:0] l_subsys;
    logic [31:0] l_intr;
    logic [31:0] l_caphdr;
    logic [31:0] l_devcap;

    assign h_subsys = be_merge(subsys_dw, cfg_req_i.wdata, cfg_req_i.be);
    assign h_intr   = be_merge(intr_dw,   cfg_req_i.wdata, cfg_req_i.be);
    assign h_caphdr = be_merge(caphdr_dw, cfg_req_i.wdata, cfg_req_i.be);
    assign h_devcap = be_merge(devcap_dw, cfg_req_i.wdata, cfg_req_i.be);
    assign l_subsys = be_merge(subsys_dw, load_i.data, load_i.be);
    assign l_intr   = be_merge(intr_dw,   load_i.data, load_i.be);
    assign l_caphdr = be_merge(caphdr_dw, load_i.data, load_i.be);
    assign l_devcap = be_merge(devcap_dw, load_i.data, load_i.be);

    logic hw_subsys;
    logic hw_intr;
    logic hw_caphdr;
    logic hw_devcap;
    logic lw_subsys;
    logic lw_intr;
    logic lw_caphdr;
    logic lw_devcap;

    assign hw_subsys = host_wr && (host_sel == SEL_SUBSYS);
    assign hw_intr   = host_wr && (host_sel == SEL_INTR);
    assign hw_caphdr = host_wr && (host_sel == SEL_CAPHDR);
    assign hw_devcap = host_wr && (host_sel == SEL_DEVCAP);
    assign lw_subsys = load_wr && (load_sel == SEL_SUBSYS);
    assign lw_intr   = load_wr && (load_sel == SEL_INTR);
    assign lw_caphdr = load_wr && (load_sel == SEL_CAPHDR);
    assign lw_devcap = load_wr && (load_sel == SEL_DEVCAP);

    ////////////////////////////////////////////////////////////////////////
    // lockable fields
    ntbc_lock_field #(.W(16), .RST(SUBSYS_VENDOR_RST)) u_subsys_vendor (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .lock_i    (wr_lock_i),
        .host_we_i (hw_subsys),                                     // RQ1
        .host_d_i  (h_subsys[POS_SUBSYS_VENDOR +: 16]),
        .load_we_i (lw_subsys),
        .load_d_i  (l_subsys[POS_SUBSYS_VENDOR +: 16]),
        .q_o       (subsys_vendor)
    );

    ntbc_lock_field #(.W(16), .RST(SUBSYS_RST)) u_subsys_code (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .lock_i    (wr_lock_i),
        .host_we_i (hw_subsys),                                     // RQ2
        .host_d_i  (h_subsys[POS_SUBSYS +: 16]),
        .load_we_i (lw_subsys),
        .load_d_i  (l_subsys[POS_SUBSYS +: 16]),
        .q_o       (subsys_code)
    );

    ntbc_lock_field #(.W(8), .RST(INTR_PIN_RST)) u_intr_pin (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .lock_i    (wr_lock_i),
        .host_we_i (hw_intr),                                       // RQ5
        .host_d_i  (h_intr[POS_INTR_PIN +: 8]),
        .load_we_i (lw_intr),
        .load_d_i  (l_intr[POS_INTR_PIN +: 8]),
        .q_o       (intr_pin)
    );

    ntbc_lock_field #(.W(4), .RST(PORT_TYPE_RST)) u_port_type (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .lock_i    (wr_lock_i),
        .host_we_i (hw_caphdr),                                     // RQ10
        .host_d_i  (h_caphdr[POS_PORT_TYPE +: 4]),
        .load_we_i (lw_caphdr),
        .load_d_i  (l_caphdr[POS_PORT_TYPE +: 4]),
        .q_o       (port_type)
    );

    ntbc_lock_field #(.W(1), .RST(SLOT_IMPL_RST)) u_slot_impl (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .lock_i    (wr_lock_i),
        .host_we_i (hw_caphdr),                                     // RQ11
        .host_d_i  (h_caphdr[POS_SLOT_IMPL +: 1]),
        .load_we_i (lw_caphdr),
        .load_d_i  (l_caphdr[POS_SLOT_IMPL +: 1]),
        .q_o       (slot_impl)
    );

    ntbc_lock_field #(.W(3), .RST(MAX_PAYLOAD_RST)) u_max_payload (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .lock_i    (wr_lock_i),
        .host_we_i (hw_devcap),                                     // RQ13
        .host_d_i  (h_devcap[POS_MAX_PAYLOAD +: 3]),
        .load_we_i (lw_devcap),
        .load_d_i  (l_devcap[POS_MAX_PAYLOAD +: 3]),
        .q_o       (max_payload)
    );

    ////////////////////////////////////////////////////////////////////////
    // indicator-present bits: read-only to the host, loader may set them
    for (genvar i = 0; i < NUM_INDICATORS; i++)
    begin : g_ind
        ntbc_lock_field #(.W(1), .RST(INDICATORS_RST[i])) u_ind (
            .clk_i     (clk_i),
            .srst_i    (srst_i),
            .lock_i    (1'b1),
            .host_we_i (1'b0),                                      // RQ18
            .host_d_i  (1'b0),
            .load_we_i (lw_devcap),                                 // RQ18
            .load_d_i  (l_devcap[POS_INDICATORS + i]),
            .q_o       (indicators[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // routing line: never locked, stored for software only
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            intr_line_q <= INTR_LINE_RST;
        else if (lw_intr)
            intr_line_q <= l_intr[POS_INTR_LINE +: 8];
        else if (hw_intr)
            intr_line_q <= h_intr[POS_INTR_LINE +: 8];              // RQ4
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; a write answers with zero data
    logic [31:0] rdata_d;

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (!cfg_req_i.write)
        begin
            case (host_sel)
                SEL_SUBSYS:  rdata_d = subsys_dw;
                SEL_CAPHEAD: rdata_d = caphead_dw;                  // RQ3
                SEL_INTR:    rdata_d = intr_dw;
                SEL_CAPHDR:  rdata_d = caphdr_dw;                   // RQ7
                SEL_DEVCAP:  rdata_d = devcap_dw;                   // RQ16
                default:     rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // answer is registered so outputs come straight from flops
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cfg_ack_o   <= 1'b0;
            cfg_hit_o   <= 1'b0;
            cfg_rdata_o <= 32'h0000_0000;
        end
        else
        begin
            cfg_ack_o   <= cfg_req_i.valid;
            cfg_hit_o   <= cfg_req_i.valid && (host_sel != SEL_NONE);
            cfg_rdata_o <= cfg_req_i.valid ? rdata_d : 32'h0000_0000;
        end
    end

    // field values that steer the rest of the bridge
    assign port_type_o   = port_type;
    assign slot_impl_o   = slot_impl;
    assign max_payload_o = max_payload;

endmodule : ntbc_cfg_header

// *** rtl/ntbc_lock_field.sv ***
// Purpose: one lockable configuration field
// Assumes: load and host data arrive already merged by byte enables
// Notes:   load wins over a host write in the same cycle
`timescale 1ns/1ps
module ntbc_lock_field #(
    parameter int unsigned   W   = 8,
    parameter logic [W-1:0]  RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic         lock_i,
    input  wire logic         host_we_i,
    input  wire logic [W-1:0] host_d_i,
    input  wire logic         load_we_i,
    input  wire logic [W-1:0] load_d_i,
    output logic      [W-1:0] q_o
);

    ////////////////////////////////////////////////////////////////////////
    // loader ignores the lock; host only while lock is open
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            q_o <= RST;
        else if (load_we_i)
            q_o <= load_d_i;                 // RQ19
        else if (host_we_i && !lock_i)
            q_o <= host_d_i;                 // RQ19
    end

endmodule : ntbc_lock_field

// *** testbench/ntbc_cfg_header_checker.sv ***
// Purpose: port assertions of the config header registers
// Assumes: answer registered one cycle after the taking edge
// Notes:   loader cycles are left out of the host write checks
`timescale 1ns/1ps
module ntbc_cfg_header_checker
    import ntbc_pkg::*;
(
    input wire logic          clk_i,
    input wire logic          srst_i,
    input wire ntbc_cfg_req_s cfg_req_i,
    input wire ntbc_load_s    load_i,
    input wire logic          wr_lock_i,
    input wire logic          cfg_ack_o,
    input wire logic          cfg_hit_o,
    input wire logic   [31:0] cfg_rdata_o,
    input wire logic   [3:0]  port_type_o,
    input wire logic          slot_impl_o,
    input wire logic   [2:0]  max_payload_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    ////////////////////////////////////////////////////////////////////////
    // host qualifiers; a same-cycle load would win, so writes exclude it
    logic       rd_v;
    logic       wr_v;
    logic [9:0] dw;
    assign rd_v = cfg_req_i.valid && !cfg_req_i.write;
    assign wr_v = cfg_req_i.valid && cfg_req_i.write && !load_i.valid;
    assign dw   = cfg_req_i.dw_addr;

    ////////////////////////////////////////////////////////////////////////
    cap_head_a: assert property (rd_v && dw == DW_CAPHEAD
        |=> cfg_hit_o && cfg_rdata_o == {24'h00_0000, CAP_HEAD_VAL})
        else $error("capability head read wrong");
    grant_lat_a: assert property (rd_v && dw == DW_INTR
        |=> cfg_hit_o && cfg_rdata_o[31:16] == 16'h0000)
        else $error("grant or latency byte not zero");
    cap_hdr_a: assert property (rd_v && dw == DW_CAPHDR
        |=> cfg_rdata_o[19:0] == 20'h1_6410 && cfg_rdata_o[31:25] == 7'h00)
        else $error("capability header constants wrong");
    dev_cap_a: assert property (rd_v && dw == DW_DEVCAP
        |=> cfg_rdata_o[11:3] == 9'h1fc && cfg_rdata_o[31:15] == 17'h0_0000)
        else $error("device capability constants wrong");
    lock_type_a: assert property (wr_v && wr_lock_i && dw == DW_CAPHDR
        |=> $stable(port_type_o) && $stable(slot_impl_o))
        else $error("locked port type or slot changed");
    lock_pay_a: assert property (wr_v && wr_lock_i && dw == DW_DEVCAP
        |=> $stable(max_payload_o))
        else $error("locked payload field changed");
    open_type_a: assert property (wr_v && !wr_lock_i && dw == DW_CAPHDR
        && cfg_req_i.be[3:2] == 2'b11
        |=> port_type_o == $past(cfg_req_i.wdata[23:20])
        && slot_impl_o == $past(cfg_req_i.wdata[24]))
        else $error("open port type or slot write lost");
    open_pay_a: assert property (wr_v && !wr_lock_i && dw == DW_DEVCAP
        && cfg_req_i.be[0] |=> max_payload_o == $past(cfg_req_i.wdata[2:0]))
        else $error("open payload write lost");
    rst_val_a: assert property ($past(srst_i)
        |-> port_type_o == PORT_TYPE_RST && slot_impl_o == SLOT_IMPL_RST
        && max_payload_o == MAX_PAYLOAD_RST)
        else $error("field reset value wrong");

    // main scenarios reached
    cover property (rd_v && dw == DW_CAPHDR);
    cover property (wr_v && wr_lock_i);
    cover property (load_i.valid && cfg_req_i.valid);
endmodule : ntbc_cfg_header_checker

bind ntbc_cfg_header ntbc_cfg_header_checker u_chk (
    .clk_i(clk_i), .srst_i(srst_i), .cfg_req_i(cfg_req_i),
    .load_i(load_i), .wr_lock_i(wr_lock_i), .cfg_ack_o(cfg_ack_o),
    .cfg_hit_o(cfg_hit_o), .cfg_rdata_o(cfg_rdata_o),
    .port_type_o(port_type_o), .slot_impl_o(slot_impl_o),
    .max_payload_o(max_payload_o)
);

// *** testbench/ntbc_host_model.sv ***
// Purpose: host configuration requester model
// Assumes: answer stands in the cycle after the taking edge
// Notes:   idle gaps model a slow host; one request at a time
`timescale 1ns/1ps
module ntbc_host_model
    import ntbc_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          cfg_ack_i,
    input  wire logic          cfg_hit_i,
    input  wire logic   [31:0] cfg_rdata_i,
    output ntbc_cfg_req_s      cfg_req_o
);
    initial cfg_req_o = '0;

    ////////////////////////////////////////////////////////////////////////
    // one transfer; valid drops after one edge since it is level sampled
    task automatic access(input logic wr, input logic [9:0] dw,
                          input logic [3:0] be, input logic [31:0] d,
                          input int gap, output logic ack,
                          output logic hit, output logic [31:0] rd);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        #1;
        cfg_req_o = {1'b1, wr, dw, be, d};
        @(posedge clk_i);
        #1;
        ack = cfg_ack_i;
        hit = cfg_hit_i;
        rd = cfg_rdata_i;
        cfg_req_o.valid = 1'b0;
        cfg_req_o.wdata = ~d; // stale data never looks valid
    endtask : access
endmodule : ntbc_host_model

// *** testbench/testbench.sv ***
// Purpose: self-checking bench of the config header registers
// Assumes: host model issues one request at a time
// Notes:   random reads, writes, loads and lock changes
`timescale 1ns/1ps
module testbench
    import ntbc_pkg::*;
;
    localparam logic [9:0] DWS [7] = '{DW_SUBSYS, DW_CAPHEAD, DW_INTR,
        DW_CAPHDR, DW_DEVCAP, 10'h012, 10'h3ff};
    logic          clk_i = 1'b0;
    logic          srst_i = 1'b1;
    logic          wr_lock_i = 1'b0;
    ntbc_load_s    load_i = '0;
    ntbc_cfg_req_s cfg_req;
    logic          ack_w, hit_w, slot_w, slot;
    logic [31:0]   rd_w, sub;
    logic [31:0]   seed = 32'h0000_0e3c;
    logic [3:0]    ptype_w, ptype;
    logic [2:0]    mpay_w, mpay, ind;
    logic [7:0]    line, pin;
    int            n_errors = 0;
    int            cmp_count = 0;

    always #25 clk_i = ~clk_i;

    ntbc_cfg_header uut (.clk_i(clk_i), .srst_i(srst_i),
        .cfg_req_i(cfg_req), .load_i(load_i), .wr_lock_i(wr_lock_i),
        .cfg_ack_o(ack_w), .cfg_hit_o(hit_w), .cfg_rdata_o(rd_w),
        .port_type_o(ptype_w), .slot_impl_o(slot_w),
        .max_payload_o(mpay_w));
    ntbc_host_model host (.clk_i(clk_i), .cfg_ack_i(ack_w),
        .cfg_hit_i(hit_w), .cfg_rdata_i(rd_w), .cfg_req_o(cfg_req));

    ////////////////////////////////////////////////////////////////////////
    // helpers: random source, expected map, shadow update
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [31:0] exp_rd(input logic [9:0] dw);
        case (dw)
            DW_SUBSYS:  return sub;
            DW_CAPHEAD: return 32'h0000_0040;
            DW_INTR:    return {16'h0000, pin, line};
            DW_CAPHDR:  return {7'h00, slot, ptype, 20'h1_6410};
            DW_DEVCAP:  return {17'h0_0000, ind, 9'h1fc, mpay};
            default:    return 32'h0000_0000;
        endcase
    endfunction : exp_rd

    // loads bypass the lock; indicator bits take loads only
    function automatic void upd(input logic ld, input logic [9:0] dw,
                                input logic [3:0] be, input logic [31:0] d);
        logic ok;
        ok = ld || !wr_lock_i;
        for (int k = 0; k < 4; k++)
            if (dw == DW_SUBSYS && be[k] && ok) sub[8*k+:8] = d[8*k+:8];
        if (dw == DW_INTR && be[0]) line = d[7:0];
        if (dw == DW_INTR && be[1] && ok) pin = d[15:8];
        if (dw == DW_CAPHDR && be[2] && ok) ptype = d[23:20];
        if (dw == DW_CAPHDR && be[3] && ok) slot = d[24];
        if (dw == DW_DEVCAP && be[0] && ok) mpay = d[2:0];
        if (dw == DW_DEVCAP && be[1] && ld) ind = d[14:12];
    endfunction : upd

    task automatic chk(input string nm, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////
    // bus, loader and reset tasks
    task automatic hx(input logic wr, input logic [9:0] dw,
                      input logic [3:0] be, input logic [31:0] d);
        logic        a, h, m;
        logic [31:0] r, e;
        e = wr ? 32'h0000_0000 : exp_rd(dw);
        m = dw inside {DW_SUBSYS, DW_CAPHEAD, DW_INTR, DW_CAPHDR, DW_DEVCAP};
        host.access(wr, dw, be, d, int'(xs() % 3), a, h, r);
        if (wr) upd(1'b0, dw, be, d);
        chk("ack", 32'(a), 32'h0000_0001);
        chk("hit", 32'(h), 32'(m));
        chk("rdata", r, e);
        chk("port_type", 32'(ptype_w), 32'(ptype));
        chk("slot", 32'(slot_w), 32'(slot));
        chk("payload", 32'(mpay_w), 32'(mpay));
    endtask : hx

    task automatic ld(input logic [9:0] dw, input logic [3:0] be,
                      input logic [31:0] d);
        @(posedge clk_i);
        #1;
        load_i = {1'b1, dw, be, d};
        upd(1'b1, dw, be, d);
        @(posedge clk_i);
        #1;
        load_i.valid = 1'b0;
        load_i.data = ~d;
    endtask : ld

    task automatic rst();
        srst_i = 1'b1;
        {sub, line, pin, ptype, slot, ind} = '0;
        mpay = 3'h4;
        repeat (4) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
    endtask : rst

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic        a, h;
        logic [31:0] r;
        rst();
        foreach (DWS[k]) hx(1'b0, DWS[k], 4'hf, 32'h0000_0000);
        // open then locked full writes; routing line ignores the lock
        for (int p = 0; p < 2; p++)
        begin
            wr_lock_i = p[0];
            foreach (DWS[k]) hx(1'b1, DWS[k], 4'hf, p ? '0 : '1);
            foreach (DWS[k]) hx(1'b0, DWS[k], 4'hf, 32'h0000_0000);
        end
        ld(DW_DEVCAP, 4'h3, 32'h0000_7003);
        hx(1'b0, DW_DEVCAP, 4'hf, 32'h0000_0000);
        // host write and load on one edge: load wins
        wr_lock_i = 1'b0;
        fork
            host.access(1'b1, DW_CAPHDR, 4'hc, 32'h0150_0000, 0, a, h, r);
            ld(DW_CAPHDR, 4'hc, 32'h00a0_0000);
        join
        hx(1'b0, DW_CAPHDR, 4'hf, 32'h0000_0000);
        for (int i = 0; i < 150; i++)
        begin
            r = xs();
            wr_lock_i = r[0] & r[1];
            if (r[4:2] == 3'h0)
                ld(DWS[int'(r[7:5]) % 7], r[11:8], xs());
            else
                hx(r[12], DWS[int'(r[7:5]) % 7], r[11:8], xs());
        end
        rst();
        foreach (DWS[k]) hx(1'b0, DWS[k], 4'hf, 32'h0000_0000);
        print_verdict();
    end

    // hang guard
    initial
    begin
        repeat (6000) @(posedge clk_i);
        n_errors++;
        print_verdict();
    end
endmodule : testbench
